// *** src/tmc_pkg.sv ***
package tmc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [19:0] ADDR_MODE_CLOCK = 20'hF0381;
    localparam logic [19:0] ADDR_PULSE_CFG = 20'hF0382;
    localparam logic [7:0] RESET_MODE_CLOCK = 8'h00;
    localparam logic [7:0] RESET_PULSE_CFG = 8'h00;
    localparam logic [7:0] WMASK_MODE_CLOCK = 8'hFB;
    localparam logic [7:0] WMASK_PULSE_CFG = 8'h7F;

    // ****************************************
    // field positions
    // ****************************************
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int CLKDIV_HI = 5;
    localparam int CLKDIV_LO = 4;
    localparam int DRIVE_BIT = 3;
    localparam int CHARGE_BIT = 1;
    localparam int POWER_BIT = 0;
    localparam int NR_OFF_BIT = 6;
    localparam int BASE_HI = 5;
    localparam int BASE_LO = 4;
    localparam int RATIO_HI = 3;
    localparam int RATIO_LO = 0;

    // ****************************************
    // encodings and counts
    // ****************************************
    localparam logic [1:0] MODE_SELF_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SELF_MULTI = 2'h1;
    localparam logic [1:0] MODE_MUTUAL = 2'h3;
    localparam logic [1:0] DIV_1 = 2'h0;
    localparam logic [1:0] DIV_2 = 2'h1;
    localparam logic [1:0] DIV_4 = 2'h2;
    localparam logic [1:0] BASE_510 = 2'h0;
    localparam logic [1:0] BASE_126 = 2'h1;
    localparam logic [1:0] BASE_62 = 2'h2;
    localparam logic [8:0] PULSES_510 = 9'h1FE;
    localparam logic [8:0] PULSES_126 = 9'h07E;
    localparam logic [8:0] PULSES_62 = 9'h03E;
    localparam logic [8:0] BASE_OFFSET = 9'h002;

endpackage : tmc_pkg

// *** src/tmc_byte_reg.sv ***
`timescale 1ns/1ps
// one byte register with bit or byte writes; masked bits hold zero
module tmc_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hFF
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // write port
    input wire logic sel_i,
    input wire logic wr_i,
    input wire logic bit_mode_i,
    input wire logic [2:0] bit_idx_i,
    input wire logic [7:0] wdata_i,
    // value
    output logic [7:0] q_o
);
    logic [7:0] next_q;

    always_comb begin
        next_q = q_o;
        if (sel_i && wr_i) begin
            if (bit_mode_i) begin
                next_q[bit_idx_i] = wdata_i[0];
            end else begin
                next_q = wdata_i;
            end
        end
        next_q = next_q & WMASK;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            q_o <= RESET_VAL;
        end else if (ce_i) begin
            q_o <= next_q;
        end
    end
endmodule : tmc_byte_reg

// *** src/tmc_config_regs.sv ***
`timescale 1ns/1ps
module tmc_config_regs (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register access
    input wire logic [19:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bit_mode_i,
    input wire logic [2:0] bit_idx_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // decoded controls
    output logic [1:0] measure_mode_sel_o,
    output logic mode_prohibited_o,
    output logic [1:0] op_clock_div_sel_o,
    output logic op_clock_en_o,
    output logic supply_drive_high_o,
    output logic filter_cap_charge_sw_o,
    output logic touch_power_on_o,
    output logic highpass_nr_disable_o,
    output logic [8:0] base_pulses_o,
    output logic [12:0] measure_pulses_o,
    output logic [13:0] measure_time_clocks_o
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        // bus side
        logic [7:0] rdata;
        // touch clock divider
        logic [1:0] div_cnt;
        logic op_clock_en;
        // mode/clock register fields
        logic [1:0] mode;
        logic mode_bad;
        logic [1:0] div_sel;
        logic drive;
        logic charge;
        logic power;
        // pulse configuration fields and derived counts
        logic nr_off;
        logic [8:0] base;
        logic [12:0] pulses;
        logic [13:0] time_clk;
    } tmc_state_s;

    tmc_state_s st;
    tmc_state_s next_st;
    logic [7:0] mode_clock;
    logic [7:0] pulse_cfg;
    logic sel_mode_clock;
    logic sel_pulse_cfg;

    // ****************************************
    // address decode
    // ****************************************
    // exact match only; any other address selects nothing and reads zero
    always_comb begin
        sel_mode_clock = 1'b0;
        sel_pulse_cfg = 1'b0;
        if (addr_i == tmc_pkg::ADDR_MODE_CLOCK) begin
            sel_mode_clock = 1'b1;
        end else if (addr_i == tmc_pkg::ADDR_PULSE_CFG) begin
            sel_pulse_cfg = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    tmc_byte_reg #(
        .RESET_VAL(tmc_pkg::RESET_MODE_CLOCK),
        .WMASK(tmc_pkg::WMASK_MODE_CLOCK)
    ) u_mode_clock (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sel_i(sel_mode_clock),
        .wr_i(wr_i),
        .bit_mode_i(bit_mode_i),
        .bit_idx_i(bit_idx_i),
        .wdata_i(wdata_i),
        .q_o(mode_clock)
    );

    tmc_byte_reg #(
        .RESET_VAL(tmc_pkg::RESET_PULSE_CFG),
        .WMASK(tmc_pkg::WMASK_PULSE_CFG)
    ) u_pulse_cfg (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .sel_i(sel_pulse_cfg),
        .wr_i(wr_i),
        .bit_mode_i(bit_mode_i),
        .bit_idx_i(bit_idx_i),
        .wdata_i(wdata_i),
        .q_o(pulse_cfg)
    );

    // ****************************************
    // decode
    // ****************************************
    always_comb begin
        logic [1:0] bsel;
        logic [3:0] ratio;
        logic [12:0] mp;
        logic [8:0] qterm;
        bsel = pulse_cfg[tmc_pkg::BASE_HI:tmc_pkg::BASE_LO];
        ratio = pulse_cfg[tmc_pkg::RATIO_HI:tmc_pkg::RATIO_LO];
        mp = 13'h0000;
        qterm = 9'h000;
        next_st = st;

        // read data only moves on a strobed read, so it stands until the next one
        if (rd_i) begin
            if (sel_mode_clock) begin
                next_st.rdata = mode_clock;
            end else if (sel_pulse_cfg) begin
                next_st.rdata = pulse_cfg;
            end else begin
                next_st.rdata = 8'h00;
            end
        end

        next_st.mode = mode_clock[tmc_pkg::MODE_HI:tmc_pkg::MODE_LO];
        next_st.mode_bad = (next_st.mode == 2'h2);
        next_st.div_sel = mode_clock[tmc_pkg::CLKDIV_HI:tmc_pkg::CLKDIV_LO];
        // divided touch clock as a one-cycle enable; prohibited code stops it
        next_st.div_cnt = st.div_cnt + 2'h1;
        case (next_st.div_sel)
            tmc_pkg::DIV_1: begin
                next_st.op_clock_en = 1'b1;
            end
            tmc_pkg::DIV_2: begin
                next_st.op_clock_en = (st.div_cnt[0] == 1'b1);
            end
            tmc_pkg::DIV_4: begin
                next_st.op_clock_en = (st.div_cnt == 2'h3);
            end
            default: begin
                next_st.op_clock_en = 1'b0;
            end
        endcase
        next_st.drive = mode_clock[tmc_pkg::DRIVE_BIT];
        next_st.charge = mode_clock[tmc_pkg::CHARGE_BIT];
        next_st.power = mode_clock[tmc_pkg::POWER_BIT];

        next_st.nr_off = pulse_cfg[tmc_pkg::NR_OFF_BIT];
        case (bsel)
            tmc_pkg::BASE_510: begin
                next_st.base = tmc_pkg::PULSES_510;
            end
            tmc_pkg::BASE_126: begin
                next_st.base = tmc_pkg::PULSES_126;
            end
            tmc_pkg::BASE_62: begin
                next_st.base = tmc_pkg::PULSES_62;
            end
            default: begin
                next_st.base = 9'h000;
            end
        endcase
        mp = 13'(next_st.base * ({1'b0, ratio} + 5'h01));
        next_st.pulses = mp;
        // quarter term truncated to whole base clocks
        qterm = 9'((next_st.base - tmc_pkg::BASE_OFFSET) >> 2);
        next_st.time_clk = {1'b0, mp} + {5'h00, qterm};
        // prohibited base code means no measurement, hence no time either
        if (next_st.base == 9'h000) begin
            next_st.time_clk = 14'h0000;
        end
    end

    // ****************************************
    // state update
    // ****************************************
    // ce_i low freezes the divider and every decoded output with the registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_o = st.rdata;
    assign measure_mode_sel_o = st.mode;
    assign mode_prohibited_o = st.mode_bad;
    assign op_clock_div_sel_o = st.div_sel;
    assign op_clock_en_o = st.op_clock_en;
    assign supply_drive_high_o = st.drive;
    assign filter_cap_charge_sw_o = st.charge;
    assign touch_power_on_o = st.power;
    assign highpass_nr_disable_o = st.nr_off;
    assign base_pulses_o = st.base;
    assign measure_pulses_o = st.pulses;
    assign measure_time_clocks_o = st.time_clk;
endmodule : tmc_config_regs

// *** testbench/tmc_config_regs_chk.sv ***
`timescale 1ns/1ps
module tmc_regs_chk (
    // watched ports
    input logic clock_i,
    input logic rst_i,
    input logic ce_i,
    input logic [19:0] addr_i,
    input logic wr_i,
    input logic rd_i,
    input logic bit_mode_i,
    input logic [2:0] bit_idx_i,
    input logic [7:0] wdata_i,
    input logic [7:0] rdata_o,
    input logic [1:0] measure_mode_sel_o,
    input logic [1:0] op_clock_div_sel_o,
    input logic op_clock_en_o,
    input logic supply_drive_high_o,
    input logic filter_cap_charge_sw_o,
    input logic [8:0] base_pulses_o,
    input logic [12:0] measure_pulses_o,
    input logic [13:0] measure_time_clocks_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    // decoded outputs trail a taken byte write by two edges
    wire w_mc = ce_i && wr_i && !bit_mode_i && addr_i == tmc_pkg::ADDR_MODE_CLOCK;
    wire w_pc = ce_i && wr_i && !bit_mode_i && addr_i == tmc_pkg::ADDR_PULSE_CFG;
    function automatic logic [8:0] base_of(input logic [1:0] c);
        return c == 2'h0 ? 9'h1FE : c == 2'h1 ? 9'h07E : c == 2'h2 ? 9'h03E : 9'h000;
    endfunction : base_of
    // ****************************************
    // properties
    // ****************************************
    AST_MODE:
        assert property (w_mc |-> ##2 measure_mode_sel_o == $past(wdata_i[7:6], 2))
        else $error("mode field lost");
    AST_DIV:
        assert property ((ce_i && op_clock_div_sel_o == 2'h0) [*3] |-> op_clock_en_o)
        else $error("undivided clock gap");
    AST_RST:
        assert property ($fell(rst_i) |-> ##1 base_pulses_o == 9'h1FE
            && !filter_cap_charge_sw_o && measure_mode_sel_o == 2'h0)
        else $error("reset values wrong");
    AST_RSVD:
        assert property (ce_i && rd_i && addr_i == tmc_pkg::ADDR_MODE_CLOCK |=> !rdata_o[2])
        else $error("reserved bit set");
    AST_BIT:
        assert property (ce_i && wr_i && bit_mode_i && bit_idx_i == 3'h3
            && addr_i == tmc_pkg::ADDR_MODE_CLOCK
            |-> ##2 supply_drive_high_o == $past(wdata_i[0], 2))
        else $error("bit write lost");
    AST_BASE:
        assert property (w_pc |-> ##2 base_pulses_o == base_of($past(wdata_i[5:4], 2)))
        else $error("base count wrong");
    AST_PULSE:
        assert property (w_pc |-> ##2 measure_pulses_o
            == 13'(base_of($past(wdata_i[5:4], 2))) * (13'($past(wdata_i[3:0], 2)) + 13'h1))
        else $error("pulse count wrong");
    AST_TIME:
        assert property (base_pulses_o != 9'h000 |-> measure_time_clocks_o
            == 14'(measure_pulses_o) + 14'((base_pulses_o - 9'h002) >> 2))
        else $error("time count wrong");
endmodule : tmc_regs_chk

bind tmc_config_regs tmc_regs_chk i_chk (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .bit_mode_i(bit_mode_i),
    .bit_idx_i(bit_idx_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .measure_mode_sel_o(measure_mode_sel_o),
    .op_clock_div_sel_o(op_clock_div_sel_o),
    .op_clock_en_o(op_clock_en_o),
    .supply_drive_high_o(supply_drive_high_o),
    .filter_cap_charge_sw_o(filter_cap_charge_sw_o),
    .base_pulses_o(base_pulses_o),
    .measure_pulses_o(measure_pulses_o),
    .measure_time_clocks_o(measure_time_clocks_o)
);

// *** testbench/tmc_config_regs_tb_top.sv ***
`timescale 1ns/1ps
module tmc_config_regs_tb_top;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic bit_mode_i = 1'b0;
    logic [2:0] bit_idx_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [19:0] addr_i = 20'h00000;
    logic [7:0] rdata_o;
    logic [1:0] measure_mode_sel_o, op_clock_div_sel_o;
    logic mode_prohibited_o, op_clock_en_o, supply_drive_high_o;
    logic filter_cap_charge_sw_o, touch_power_on_o, highpass_nr_disable_o;
    logic [8:0] base_pulses_o;
    logic [12:0] measure_pulses_o;
    logic [13:0] measure_time_clocks_o;
    int miscompares = 0;
    int checked = 0;
    localparam logic [19:0] MC = tmc_pkg::ADDR_MODE_CLOCK;
    localparam logic [19:0] PC = tmc_pkg::ADDR_PULSE_CFG;

    tmc_config_regs i_dut (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .addr_i(addr_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .bit_mode_i(bit_mode_i),
        .bit_idx_i(bit_idx_i),
        .wdata_i(wdata_i),
        .rdata_o(rdata_o),
        .measure_mode_sel_o(measure_mode_sel_o),
        .mode_prohibited_o(mode_prohibited_o),
        .op_clock_div_sel_o(op_clock_div_sel_o),
        .op_clock_en_o(op_clock_en_o),
        .supply_drive_high_o(supply_drive_high_o),
        .filter_cap_charge_sw_o(filter_cap_charge_sw_o),
        .touch_power_on_o(touch_power_on_o),
        .highpass_nr_disable_o(highpass_nr_disable_o),
        .base_pulses_o(base_pulses_o),
        .measure_pulses_o(measure_pulses_o),
        .measure_time_clocks_o(measure_time_clocks_o)
    );

    always #2.5 clock_i = ~clock_i;

    task automatic check(input logic [13:0] s, input logic [13:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask : check

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // bus tasks and scenarios
    // ****************************************
    // both tasks start and end just after an edge, so strobes never clash
    // no measurement is ever started here, so every write is a legal one
    task automatic wr(input logic [19:0] a, input logic [7:0] d,
        input logic b, input logic [2:0] x);
        addr_i = a;
        wdata_i = d;
        bit_mode_i = b;
        bit_idx_i = x;
        wr_i = 1'b1;
        @(posedge clock_i);
        #1 wr_i = 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : wr

    task automatic rdc(input logic [19:0] a, input logic [7:0] e);
        addr_i = a;
        rd_i = 1'b1;
        @(posedge clock_i);
        #1 rd_i = 1'b0;
        @(posedge clock_i);
        #1 check(rdata_o, e);
    endtask : rdc

    task automatic t_mode_clock;
        int n;
        for (int i = 0; i < 4; i++) begin
            wr(MC, {i[1:0], i[1:0], 4'hF}, 1'b0, 3'h0);
            rdc(MC, {i[1:0], i[1:0], 4'hB});
            check(measure_mode_sel_o, 14'(i));
            check(mode_prohibited_o, 14'(i == 2));
            check(op_clock_div_sel_o, 14'(i));
            check(supply_drive_high_o, 14'h1);
            check({filter_cap_charge_sw_o, touch_power_on_o}, 14'h3);
            n = 0;
            repeat (8) begin
                @(posedge clock_i);
                #1 n += int'(op_clock_en_o);
            end
            check(14'(n), i == 3 ? 14'h0 : 14'(8 >> i));
        end
        wr(MC, 8'h00, 1'b0, 3'h0);
        check({filter_cap_charge_sw_o, touch_power_on_o}, 14'h0);
        // single-bit writes avoid bits 0 and 1, which software must set together
        wr(MC, 8'h01, 1'b1, 3'h3);
        wr(MC, 8'h01, 1'b1, 3'h2);
        rdc(MC, 8'h08);
        check(supply_drive_high_o, 14'h1);
    endtask : t_mode_clock

    task automatic t_pulse;
        logic [8:0] b;
        logic [12:0] p;
        logic [13:0] t;
        for (int i = 0; i < 4; i++) begin
            b = i == 0 ? 9'h1FE : i == 1 ? 9'h07E : i == 2 ? 9'h03E : 9'h000;
            p = 13'(b) * 13'(i * 5 + 1);
            t = b == 9'h0 ? 14'h0 : 14'(p) + 14'((b - 9'h2) >> 2);
            wr(PC, {1'b1, i[0], i[1:0], 4'(i * 5)}, 1'b0, 3'h0);
            rdc(PC, {1'b0, i[0], i[1:0], 4'(i * 5)});
            check(highpass_nr_disable_o, 14'(i[0]));
            check(base_pulses_o, 14'(b));
            check(measure_pulses_o, 14'(p));
            check(measure_time_clocks_o, t);
        end
        // clearing one bit of the base field must leave the others alone
        wr(PC, 8'h00, 1'b1, 3'h5);
        rdc(PC, 8'h5F);
        check(base_pulses_o, 14'h07E);
    endtask : t_pulse

    task automatic t_misc;
        wr(20'hF0383, 8'hFF, 1'b0, 3'h0);
        rdc(20'hF0383, 8'h00);
        ce_i = 1'b0;
        wr(MC, 8'hC0, 1'b0, 3'h0);
        ce_i = 1'b1;
        rdc(MC, 8'h08);
        rst_i = 1'b1;
        @(posedge clock_i);
        #1 rst_i = 1'b0;
        rdc(MC, 8'h00);
        rdc(PC, 8'h00);
    endtask : t_misc

    initial begin
        repeat (5) @(posedge clock_i);
        #1 rst_i = 1'b0;
        rdc(MC, 8'h00);
        check(base_pulses_o, 14'h1FE);
        t_mode_clock();
        t_pulse();
        t_misc();
        test_done();
    end

    initial begin
        #20000;
        miscompares++;
        test_done();
    end
endmodule : tmc_config_regs_tb_top
